// [scbd_pkg.sv]
// Purpose: shared constants and types for the serial control, data port and baud block
// Assumes: APB register bus, one word per register, 8-bit data in the low byte
// Notes:   status and configuration registers sit after the documented ones
package scbd_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL2  = 8'h00;
   localparam logic [7:0] OFS_DATA   = 8'h04;
   localparam logic [7:0] OFS_BAUD   = 8'h08;
   localparam logic [7:0] OFS_RX_EXT = 8'h0C;
   localparam logic [7:0] OFS_TX_EXT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_CFG    = 8'h18;

   // reset values
   localparam logic [7:0] RST_CTRL2  = 8'h00;
   localparam logic [7:0] RST_BAUD   = 8'h00;
   localparam logic [7:0] RST_EXT    = 8'h00;
   localparam logic [7:0] RST_CFG    = 8'h00;
   localparam logic [4:0] RST_FLAGS  = 5'h18;

   // field positions
   localparam int PRE_MSB        = 7;
   localparam int PRE_LSB        = 6;
   localparam int TX_SEL_MSB     = 5;
   localparam int TX_SEL_LSB     = 3;
   localparam int RX_SEL_MSB     = 2;
   localparam int RX_SEL_LSB     = 0;
   localparam int CFG_WAKE_BIT   = 3;
   localparam int CFG_LIN_SL_BIT = 0;

   // first prescaler terminal counts (factor minus one)
   localparam logic [3:0] PRE_LAST_1  = 4'h0;
   localparam logic [3:0] PRE_LAST_3  = 4'h2;
   localparam logic [3:0] PRE_LAST_4  = 4'h3;
   localparam logic [3:0] PRE_LAST_13 = 4'hC;

   // timing counts in oversample ticks and bits
   localparam logic [3:0] TICK_LAST      = 4'hF;
   localparam logic [3:0] START_MID      = 4'h7;
   localparam logic [3:0] FRAME_LAST     = 4'h9;
   localparam logic [3:0] RX_STOP_BIT    = 4'h8;
   localparam logic [7:0] IDLE_TICK_LAST = 8'h9F;

   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_irq_en;
      logic quiet_line_irq_en;
      logic tx_enable;
      logic rx_enable;
      logic mute_request;
      logic send_break_ctl;
   } scbd_ctrl2_s;

   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic tx_done_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
   } scbd_flags_s;

   typedef enum logic [1:0] {TX_OFF = 2'b00, TX_WAIT = 2'b01, TX_IDLE = 2'b11,
                             TX_SHIFT = 2'b10} scbd_tx_e;
   typedef enum logic [1:0] {RX_OFF = 2'b00, RX_HUNT = 2'b01, RX_START = 2'b11,
                             RX_DATA = 2'b10} scbd_rx_e;
   typedef enum logic [1:0] {KIND_DATA = 2'b00, KIND_PRE = 2'b01,
                             KIND_BRK = 2'b11} scbd_kind_e;
endpackage

// [scbd_serial_ctrl.sv]
// Purpose: control register two, data port and baud generation of an async serial port
// Assumes: APB slave, no wait states on any access, line input is asynchronous
// Notes:   8N1 frames, 16x oversampling, no parity, no LIN header logic
`timescale 1ns/1ns
module scbd_serial_ctrl (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // serial line
   input  wire logic        rxd_pin,
   output logic             txd_pin,
   // interrupt request
   output logic             serial_irq
);
   import scbd_pkg::*;

   scbd_ctrl2_s ctrl_ff;
   scbd_flags_s flags_ff;
   scbd_tx_e    tx_state_ff;
   scbd_rx_e    rx_state_ff;
   scbd_kind_e  tx_kind_ff;
   logic [7:0]  baud_ff;
   logic [7:0]  rx_ext_ff;
   logic [7:0]  tx_ext_ff;
   logic [7:0]  cfg_ff;
   logic [7:0]  tx_holding_ff;
   logic [7:0]  rx_holding_ff;
   logic        tx_full_ff;
   logic        status_seen_ff;
   logic        idle_armed_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        irq_ff;
   logic        txd_ff;
   logic [3:0]  pre_cnt_ff;
   logic [7:0]  tx_div_ff;
   logic [7:0]  rx_div_ff;
   logic [9:0]  tx_shift_ff;
   logic [3:0]  tx_tick_ff;
   logic [3:0]  tx_bit_ff;
   logic        pend_pre_ff;
   logic        pend_brk_ff;
   logic        te_q_ff;
   logic        sbk_q_ff;
   logic        rxd_meta_ff;
   logic        rxd_sync_ff;
   logic        rxd_prev_ff;
   logic [7:0]  rx_shift_ff;
   logic [3:0]  rx_tick_ff;
   logic [3:0]  rx_bit_ff;
   logic [7:0]  idle_cnt_ff;

   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a == OFS_CTRL2) || (a == OFS_DATA) || (a == OFS_BAUD) ||
                    (a == OFS_RX_EXT) || (a == OFS_TX_EXT) || (a == OFS_STATUS) ||
                    (a == OFS_CFG);
   endfunction

   function automatic logic [3:0] pre_last(input logic [1:0] sel);
      case (sel)
         2'b00:   pre_last = PRE_LAST_1;
         2'b01:   pre_last = PRE_LAST_3;
         2'b10:   pre_last = PRE_LAST_4;
         default: pre_last = PRE_LAST_13;
      endcase
   endfunction

   // extended divisor overrides the power-of-two divisor when nonzero
   function automatic logic [7:0] div_last(input logic [7:0] ext, input logic [2:0] sel);
      if (ext != 8'h00) begin
         div_last = 8'(ext - 8'h01);
      end else begin
         div_last = 8'((8'h01 << sel) - 8'h01);
      end
   endfunction

   // bus decode
   logic setup_ph;
   logic acc_done;
   logic bus_wr;
   logic bus_rd;
   logic wr_data;
   logic rd_data;
   logic rd_status;
   assign setup_ph  = psel & ~penable;
   assign acc_done  = psel & penable & pready_ff & ~pslverr_ff;
   assign bus_wr    = acc_done & pwrite;
   assign bus_rd    = acc_done & ~pwrite;
   assign wr_data   = bus_wr & (paddr == OFS_DATA);
   assign rd_data   = bus_rd & (paddr == OFS_DATA);
   assign rd_status = bus_rd & (paddr == OFS_STATUS);

   logic wake_addr;
   logic lin_slave;
   assign wake_addr = cfg_ff[CFG_WAKE_BIT];
   assign lin_slave = cfg_ff[CFG_LIN_SL_BIT];

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (paddr == OFS_CTRL2) begin
         rd_mux = ctrl_ff;
      end else if (paddr == OFS_DATA) begin
         rd_mux = rx_holding_ff;
      end else if (paddr == OFS_BAUD) begin
         rd_mux = baud_ff;
      end else if (paddr == OFS_RX_EXT) begin
         rd_mux = rx_ext_ff;
      end else if (paddr == OFS_TX_EXT) begin
         rd_mux = tx_ext_ff;
      end else if (paddr == OFS_STATUS) begin
         rd_mux = {flags_ff, 3'b000};
      end else if (paddr == OFS_CFG) begin
         rd_mux = cfg_ff & 8'h09;
      end
   end

   // data is sampled in setup so prdata comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup_ph;
         pslverr_ff <= setup_ph & ~addr_mapped(paddr);
         if (setup_ph) begin
            prdata_ff <= {24'h00_0000, rd_mux};
         end
      end
   end

   // baud generation
   logic pre_tick;
   logic tx16;
   logic rx16;
   logic [3:0] pre_lim;
   logic [7:0] tx_lim;
   logic [7:0] rx_lim;
   assign pre_lim  = pre_last(baud_ff[PRE_MSB:PRE_LSB]);
   assign tx_lim   = div_last(tx_ext_ff, baud_ff[TX_SEL_MSB:TX_SEL_LSB]);
   assign rx_lim   = div_last(rx_ext_ff, baud_ff[RX_SEL_MSB:RX_SEL_LSB]);
   assign pre_tick = ~lin_slave & (pre_cnt_ff >= pre_lim);
   assign tx16     = pre_tick & (tx_div_ff >= tx_lim);
   assign rx16     = pre_tick & (rx_div_ff >= rx_lim);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_ff <= 4'h0;
         tx_div_ff  <= 8'h00;
         rx_div_ff  <= 8'h00;
      end else if (lin_slave) begin
         pre_cnt_ff <= 4'h0;
         tx_div_ff  <= 8'h00;
         rx_div_ff  <= 8'h00;
      end else begin
         pre_cnt_ff <= pre_tick ? 4'h0 : 4'(pre_cnt_ff + 4'h1);
         if (pre_tick) begin
            tx_div_ff <= tx16 ? 8'h00 : 8'(tx_div_ff + 8'h01);
            rx_div_ff <= rx16 ? 8'h00 : 8'(rx_div_ff + 8'h01);
         end
      end
   end

   // configuration registers
   logic wake_evt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_ff   <= RST_BAUD;
         rx_ext_ff <= RST_EXT;
         tx_ext_ff <= RST_EXT;
         cfg_ff    <= RST_CFG;
      end else if (bus_wr) begin
         if (paddr == OFS_BAUD) begin
            baud_ff <= pwdata[7:0];
         end else if (paddr == OFS_RX_EXT) begin
            rx_ext_ff <= pwdata[7:0];
         end else if (paddr == OFS_TX_EXT) begin
            tx_ext_ff <= pwdata[7:0];
         end else if (paddr == OFS_CFG) begin
            cfg_ff <= pwdata[7:0] & 8'h09;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= RST_CTRL2;
      end else begin
         if (bus_wr && (paddr == OFS_CTRL2)) begin
            ctrl_ff <= pwdata[7:0];
            if (wake_addr && flags_ff.rx_full_flag) begin
               ctrl_ff.mute_request <= ctrl_ff.mute_request;
            end
         end
         if (wake_evt) begin
            ctrl_ff.mute_request <= 1'b0;
         end
      end
   end

   // transmitter
   logic tx_frame_end;
   logic tx_brk_req;
   logic tx_load;
   assign tx_brk_req   = ctrl_ff.send_break_ctl | pend_brk_ff;
   assign tx_frame_end = (tx_state_ff == TX_SHIFT) & tx16 & (tx_tick_ff == TICK_LAST) &
                         (tx_bit_ff == FRAME_LAST);
   assign tx_load      = (tx_state_ff == TX_IDLE) & ctrl_ff.tx_enable & ~tx_brk_req &
                         ~pend_pre_ff & tx_full_ff & ~lin_slave;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_holding_ff <= 8'h00;
         tx_full_ff    <= 1'b0;
      end else begin
         if (tx_load) begin
            tx_full_ff <= 1'b0;
         end
         if (wr_data) begin
            tx_holding_ff <= pwdata[7:0];
            tx_full_ff    <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         te_q_ff     <= 1'b0;
         sbk_q_ff    <= 1'b0;
         pend_pre_ff <= 1'b0;
         pend_brk_ff <= 1'b0;
      end else begin
         te_q_ff  <= ctrl_ff.tx_enable;
         sbk_q_ff <= ctrl_ff.send_break_ctl;
         if (ctrl_ff.tx_enable && !te_q_ff && tx_state_ff == TX_SHIFT) begin
            pend_pre_ff <= 1'b1;
         end else if (tx_state_ff == TX_IDLE && !tx_brk_req && !lin_slave) begin
            pend_pre_ff <= 1'b0;
         end
         if (!ctrl_ff.send_break_ctl && sbk_q_ff && tx_state_ff == TX_SHIFT) begin
            pend_brk_ff <= 1'b1;
         end else if (tx_state_ff == TX_IDLE && !lin_slave) begin
            pend_brk_ff <= 1'b0;
         end
      end
   end

   // a frame in flight completes even if the enable drops, but holds while lin_slave stops the ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_ff <= TX_OFF;
         tx_kind_ff  <= KIND_DATA;
         tx_shift_ff <= 10'h3FF;
         tx_tick_ff  <= 4'h0;
         tx_bit_ff   <= 4'h0;
         txd_ff      <= 1'b1;
      end else begin
         case (tx_state_ff)
            TX_OFF: begin
               txd_ff     <= 1'b1;
               tx_tick_ff <= 4'h0;
               if (ctrl_ff.tx_enable) begin
                  tx_state_ff <= TX_WAIT;
               end
            end
            TX_WAIT: begin
               if (!ctrl_ff.tx_enable) begin
                  tx_state_ff <= TX_OFF;
               end else if (tx16) begin
                  tx_tick_ff <= 4'(tx_tick_ff + 4'h1);
                  if (tx_tick_ff == TICK_LAST) begin
                     tx_state_ff <= TX_IDLE;
                  end
               end
            end
            TX_IDLE: begin
               txd_ff     <= 1'b1;
               tx_tick_ff <= 4'h0;
               tx_bit_ff  <= 4'h0;
               if (!ctrl_ff.tx_enable) begin
                  tx_state_ff <= TX_OFF;
               end else if (lin_slave) begin
                  // no ticks means no frame may start, the line stays idle
                  tx_state_ff <= TX_IDLE;
               end else if (tx_brk_req) begin
                  tx_kind_ff  <= KIND_BRK;
                  tx_shift_ff <= 10'h000;
                  tx_state_ff <= TX_SHIFT;
               end else if (pend_pre_ff) begin
                  tx_kind_ff  <= KIND_PRE;
                  tx_shift_ff <= 10'h3FF;
                  tx_state_ff <= TX_SHIFT;
               end else if (tx_load) begin
                  tx_kind_ff  <= KIND_DATA;
                  tx_shift_ff <= {1'b1, tx_holding_ff, 1'b0};
                  tx_state_ff <= TX_SHIFT;
               end
            end
            default: begin
               txd_ff <= tx_shift_ff[0];
               if (tx16) begin
                  tx_tick_ff <= 4'(tx_tick_ff + 4'h1);
                  if (tx_tick_ff == TICK_LAST) begin
                     tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
                     tx_bit_ff   <= 4'(tx_bit_ff + 4'h1);
                     if (tx_bit_ff == FRAME_LAST) begin
                        tx_state_ff <= TX_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   // receiver: two flops before anything looks at the line
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxd_meta_ff <= 1'b1;
         rxd_sync_ff <= 1'b1;
         rxd_prev_ff <= 1'b1;
      end else begin
         rxd_meta_ff <= rxd_pin;
         rxd_sync_ff <= rxd_meta_ff;
         rxd_prev_ff <= rxd_sync_ff;
      end
   end

   logic rx_done;
   logic idle_evt;
   logic rx_keep;
   assign rx_done  = (rx_state_ff == RX_DATA) & rx16 & (rx_tick_ff == TICK_LAST) &
                     (rx_bit_ff == RX_STOP_BIT);
   assign idle_evt = (rx_state_ff == RX_HUNT) & rx16 & rxd_sync_ff &
                     (idle_cnt_ff == IDLE_TICK_LAST);
   // in mute with wake_addr set only an address mark byte gets through, and it wakes the receiver; with wake_addr clear no byte does
   assign rx_keep  = rx_done & (~ctrl_ff.mute_request | (wake_addr & rx_shift_ff[7]));
   assign wake_evt = ctrl_ff.mute_request & ((wake_addr & rx_done & rx_shift_ff[7]) |
                     (~wake_addr & idle_evt & idle_armed_ff));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state_ff <= RX_OFF;
         rx_shift_ff <= 8'h00;
         rx_tick_ff  <= 4'h0;
         rx_bit_ff   <= 4'h0;
         idle_cnt_ff <= 8'h00;
      end else if (!ctrl_ff.rx_enable) begin
         rx_state_ff <= RX_OFF;
         idle_cnt_ff <= 8'h00;
      end else begin
         case (rx_state_ff)
            RX_OFF: begin
               rx_state_ff <= RX_HUNT;
            end
            RX_HUNT: begin
               rx_tick_ff <= 4'h0;
               rx_bit_ff  <= 4'h0;
               if (rxd_prev_ff && !rxd_sync_ff) begin
                  rx_state_ff <= RX_START;
                  idle_cnt_ff <= 8'h00;
               end else if (!rxd_sync_ff) begin
                  idle_cnt_ff <= 8'h00;
               end else if (rx16 && idle_cnt_ff != IDLE_TICK_LAST + 8'h01) begin
                  idle_cnt_ff <= 8'(idle_cnt_ff + 8'h01);
               end
            end
            RX_START: begin
               if (rx16) begin
                  rx_tick_ff <= 4'(rx_tick_ff + 4'h1);
                  if (rx_tick_ff == START_MID) begin
                     rx_tick_ff  <= 4'h0;
                     rx_state_ff <= rxd_sync_ff ? RX_HUNT : RX_DATA;
                  end
               end
            end
            default: begin
               if (rx16) begin
                  rx_tick_ff <= 4'(rx_tick_ff + 4'h1);
                  if (rx_tick_ff == TICK_LAST) begin
                     rx_bit_ff <= 4'(rx_bit_ff + 4'h1);
                     if (rx_bit_ff == RX_STOP_BIT) begin
                        rx_state_ff <= RX_HUNT;
                     end else begin
                        rx_shift_ff <= {rxd_sync_ff, rx_shift_ff[7:1]};
                     end
                  end
               end
            end
         endcase
      end
   end

   // on overrun the holding byte survives and the new one is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_holding_ff <= 8'h00;
      end else if (rx_keep && !flags_ff.rx_full_flag) begin
         rx_holding_ff <= rx_shift_ff;
      end
   end

   // status flags: clears need a status read first, hardware sets win
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_ff       <= RST_FLAGS;
         status_seen_ff <= 1'b0;
         idle_armed_ff  <= 1'b0;
      end else begin
         if (rd_status) begin
            status_seen_ff <= 1'b1;
         end else if (wr_data || rd_data) begin
            status_seen_ff <= 1'b0;
         end
         if (wr_data && status_seen_ff) begin
            flags_ff.tx_buffer_empty_flag <= 1'b0;
            flags_ff.tx_done_flag         <= 1'b0;
         end
         if (rd_data && status_seen_ff) begin
            flags_ff.rx_full_flag <= 1'b0;
            flags_ff.idle_flag    <= 1'b0;
            flags_ff.overrun_flag <= 1'b0;
         end
         if (tx_load) begin
            flags_ff.tx_buffer_empty_flag <= 1'b1;
         end
         if (tx_frame_end && tx_kind_ff == KIND_DATA) begin
            flags_ff.tx_done_flag <= 1'b1;
         end
         if (rx_keep && flags_ff.rx_full_flag) begin
            flags_ff.overrun_flag <= 1'b1;
         end else if (rx_keep) begin
            flags_ff.rx_full_flag <= 1'b1;
            idle_armed_ff         <= 1'b1;
         end
         if (idle_evt && idle_armed_ff && !ctrl_ff.mute_request) begin
            flags_ff.idle_flag <= 1'b1;
            idle_armed_ff      <= 1'b0;
         end else if (idle_evt && wake_evt) begin
            idle_armed_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (ctrl_ff.tx_empty_irq_en & flags_ff.tx_buffer_empty_flag) |
                   (ctrl_ff.tx_done_irq_en & flags_ff.tx_done_flag) |
                   (ctrl_ff.rx_irq_en & (flags_ff.overrun_flag | flags_ff.rx_full_flag)) |
                   (ctrl_ff.quiet_line_irq_en & flags_ff.idle_flag);
      end
   end

   assign prdata     = prdata_ff;
   assign pready     = pready_ff;
   assign pslverr    = pslverr_ff;
   assign txd_pin    = txd_ff;
   assign serial_irq = irq_ff;
endmodule

// [scbd_serial_ctrl_props.sv]
// Purpose: port checks for scbd_serial_ctrl
// Assumes: apb master keeps the hand-over timing
// Notes:   config is tracked from bus writes, not read from the design
`timescale 1ns/1ns
module scbd_serial_ctrl_props
   import scbd_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // line and irq
   input wire logic        rxd_pin,
   input wire logic        txd_pin,
   input wire logic        serial_irq
);
   logic setup;
   logic mapped;
   logic lin_ff;
   assign setup  = psel && !penable;
   assign mapped = paddr inside {OFS_CTRL2, OFS_DATA, OFS_BAUD, OFS_RX_EXT, OFS_TX_EXT,
                                 OFS_STATUS, OFS_CFG};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lin_ff <= 1'b0;
      end else if (pready && pwrite && paddr == OFS_CFG) begin
         lin_ff <= pwdata[CFG_LIN_SL_BIT];
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (setup |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("pready without setup");
   a_err_unmapped: assert property (setup && !mapped |=> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (setup && mapped |=> !pslverr)
      else $error("error on mapped address");
   a_err_rd_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_rd_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   a_rd_hold: assert property (!setup |=> $stable(prdata))
      else $error("read data moved outside setup");
   a_irq_masked: assert property (pready && pwrite && paddr == OFS_CTRL2
      && !pslverr && pwdata[7:4] == 4'h0 |-> ##2 !serial_irq)
      else $error("irq with all enables clear");
   a_lin_frozen: assert property (lin_ff ##1 lin_ff |=> $stable(txd_pin))
      else $error("line moved in lin slave mode");
   a_txd_idle_reset: assert property ($rose(presetn) |-> txd_pin)
      else $error("line not idle after reset");
endmodule

bind scbd_serial_ctrl scbd_serial_ctrl_props scbd_serial_ctrl_props_i (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd_pin,
   .txd_pin, .serial_irq);

// [scbd_line_node.sv]
// Purpose: remote serial node on the line
// Assumes: 8N1 frames, rate given in clocks per bit
// Notes:   idle line driven high from time zero
`timescale 1ns/1ns
module scbd_line_node (
   // clock
   input  wire logic clk,
   // serial wires
   input  wire logic txd,
   output logic      rxd
);
   int         bit_cyc = 16;
   int         frames = 0;
   logic [7:0] got = 8'h00;
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (bit_cyc) @(posedge clk);
      end
   endtask
   // mid-bit sampling, so a wrong rate shows up as a wrong byte
   always begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge clk);
         got[i] = txd;
      end
      repeat (bit_cyc) @(posedge clk);
      frames++;
   end
endmodule

// [tb_top.sv]
// Purpose: directed test of scbd_serial_ctrl over apb and the line
// Assumes: line node plays the remote end
// Notes:   baud 0 gives 16 clocks per bit
`timescale 1ns/1ns
module tb_top;
   import scbd_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        rxd_pin;
   logic        txd_pin;
   logic        serial_irq;
   logic [31:0] rd;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n;
   int          gap;
   logic [7:0]  bt [6] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'h18, 8'h18};
   logic [7:0]  ex [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
   int          bc [6] = '{16, 48, 64, 208, 128, 80};
   logic [7:0]  rb [3] = '{8'h02, 8'h02, 8'h00};
   logic [7:0]  re [3] = '{8'h00, 8'h03, 8'h00};
   int          rc [3] = '{64, 48, 16};

   always #25 pclk = ~pclk;

   scbd_serial_ctrl scbd_serial_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rxd_pin, .txd_pin, .serial_irq);
   scbd_line_node scbd_line_node_i (.clk(pclk), .txd(txd_pin), .rxd(rxd_pin));

   task automatic results();
      if (miscompares == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h00_0000, d});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check($sformatf("reg_%h", a), rd, e);
   endtask
   task automatic irq(input logic [7:0] c, input logic e);
      wr(OFS_CTRL2, c);
      repeat (2) @(posedge pclk);
      check("serial_irq", {31'h0, serial_irq}, {31'h0, e});
   endtask
   task automatic zeros(input int len);
      n = 0;
      repeat (len) begin
         @(posedge pclk);
         n += (txd_pin === 1'b0);
      end
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(OFS_BAUD, 32'h0000_0000);
      rdc(OFS_RX_EXT, 32'h0000_0000);
      rdc(OFS_TX_EXT, 32'h0000_0000);
      rdc(OFS_STATUS, 32'h0000_00C0);
      rdc(8'h1C, 32'h0000_0000);
      irq(8'h80, 1'b1);
      irq(8'h00, 1'b0);
      irq(8'h40, 1'b1);
      wr(OFS_DATA, 8'hA5);
      wr(OFS_CTRL2, 8'h08);
      n = 0;
      while (txd_pin === 1'b1) begin
         @(posedge pclk);
         n++;
      end
      check("start delay", 32'(n >= 16 && n <= 40), 32'h0000_0001);
      wait (scbd_line_node_i.frames == 1);
      check("tx byte", scbd_line_node_i.got, 8'hA5);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("tx empty", rd & 32'h0000_0080, 32'h0000_0080);
      foreach (bt[i]) begin
         wr(OFS_BAUD, bt[i]);
         wr(OFS_TX_EXT, ex[i]);
         scbd_line_node_i.bit_cyc = bc[i];
         n = scbd_line_node_i.frames;
         wr(OFS_DATA, 8'(8'h3C + i));
         wait (scbd_line_node_i.frames == n + 1);
         check("tx rate", scbd_line_node_i.got, 8'h3C + i);
      end
      wr(OFS_TX_EXT, 8'h00);
      wr(OFS_CTRL2, 8'h0C);
      foreach (rb[i]) begin
         wr(OFS_BAUD, rb[i]);
         wr(OFS_RX_EXT, re[i]);
         scbd_line_node_i.bit_cyc = rc[i];
         scbd_line_node_i.send(8'(8'h5A ^ i));
         repeat (20) @(posedge pclk);
         apb(1'b0, OFS_STATUS, 32'h0000_0000);
         rdc(OFS_DATA, 8'h5A ^ i);
      end
      n = scbd_line_node_i.frames;
      wr(OFS_DATA, 8'h81);
      wr(OFS_DATA, 8'h42);
      wr(OFS_CTRL2, 8'h04);
      wr(OFS_CTRL2, 8'h0C);
      wait (scbd_line_node_i.frames == n + 1);
      gap = cyc;
      wait (scbd_line_node_i.frames == n + 2);
      check("preamble gap", 32'(cyc - gap >= 300), 32'h0000_0001);
      repeat (200) @(posedge pclk);
      irq(8'h1C, 1'b1);
      irq(8'h0C, 1'b0);
      scbd_line_node_i.send(8'h33);
      irq(8'h2C, 1'b1);
      wr(OFS_CFG, 8'h08);
      wr(OFS_CTRL2, 8'h0E);
      rdc(OFS_CTRL2, 32'h0000_000C);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      apb(1'b0, OFS_DATA, 32'h0000_0000);
      wr(OFS_CTRL2, 8'h0E);
      rdc(OFS_CTRL2, 32'h0000_000E);
      scbd_line_node_i.send(8'h11);
      repeat (20) @(posedge pclk);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check("rx full", rd & 32'h0000_0020, 32'h0000_0000);
      scbd_line_node_i.send(8'h81);
      repeat (20) @(posedge pclk);
      rdc(OFS_CTRL2, 32'h0000_000C);
      rdc(OFS_DATA, 32'h0000_0081);
      wr(OFS_CFG, 8'h00);
      wr(OFS_CTRL2, 8'h0E);
      repeat (200) @(posedge pclk);
      rdc(OFS_CTRL2, 32'h0000_000C);
      wr(OFS_CTRL2, 8'h09);
      zeros(200);
      check("break", 32'(n >= 150), 32'h0000_0001);
      wr(OFS_CTRL2, 8'h08);
      zeros(400);
      check("queued break", 32'(n >= 250), 32'h0000_0001);
      wr(OFS_CFG, 8'h01);
      wr(OFS_DATA, 8'h00);
      zeros(400);
      check("lin idle", n, 32'h0000_0000);
      results();
   end
endmodule
